// file: hdl/cal_sched_consts.vh
// Purpose: Constants for the self calibration scheduler.
// Assumes: 10 MHz system clock, APB register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
`ifndef CAL_SCHED_CONSTS_VH
`define CAL_SCHED_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define CS_OFF_CTRL      12'h000
`define CS_OFF_STATUS    12'h004
`define CS_OFF_TEMP      12'h008
`define CS_OFF_TEMPTHR   12'h00c
`define CS_OFF_TIMELIM   12'h010
`define CS_OFF_ELAPSED   12'h014

// ****************************************
// Field positions
// ****************************************
`define CS_CTRL_EN_BIT    0
`define CS_CTRL_START_BIT 1
`define CS_STAT_BUSY_BIT  2

// ****************************************
// Status codes
// ****************************************
`define CS_ST_UNCAL      2'h0
`define CS_ST_CAL        2'h1
`define CS_ST_RECOMMEND  2'h2

// ****************************************
// Reset values
// ****************************************
`define CS_RST_EN        1'h1
`define CS_RST_TEMPTHR   16'h0100
`define CS_RST_TIMELIM   32'h0000_0e10

// ****************************************
// Timing
// ****************************************
`define CS_CLK_HZ        10000000
`define CS_WARMUP_MIN    16
`define CS_CALRUN_MS     1000
// Sized at 34 bits: the full warm-up count does not fit a 32-bit integer.
`define CS_WARMUP_CYC    (34'd60 * `CS_WARMUP_MIN * `CS_CLK_HZ)
`define CS_CALRUN_CYC    (`CS_CALRUN_MS * (`CS_CLK_HZ / 1000))
`define CS_SEC_CYC       `CS_CLK_HZ

`endif

// file: hdl/cal_timer.v
// Purpose: Down counter that pulses once when a loaded count runs out.
// Assumes: Synchronous load, asynchronous active-high reset.
// Notes:   A load of zero finishes on the next cycle.
`timescale 1ns/1ns
`default_nettype none
module cal_timer #(
	parameter WIDTH = 34
) (
	// Clock and reset
	input  wire             clk,
	input  wire             sys_rst,
	// Control
	input  wire             load,
	input  wire [WIDTH-1:0] count,
	input  wire             abort,
	// Status
	output reg              running,
	output reg              done
);
	reg [WIDTH-1:0] cnt_r;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r   <= {WIDTH{1'b0}};
			running <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				running <= 1'b0;
			end else if (load) begin
				cnt_r   <= count;
				running <= 1'b1;
			end else if (running) begin
				if (cnt_r == {WIDTH{1'b0}}) begin
					running <= 1'b0;
					done    <= 1'b1;
				end else begin
					cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/self_calibration_scheduler.v
// Purpose: Schedules front-end self calibration and keeps a three-state status.
// Assumes: APB slave, 10 MHz clock, temperature sample supplied on a port.
// Notes:   The analog calibration is outside; this block only sequences it.
`timescale 1ns/1ns
`default_nettype none
`include "cal_sched_consts.vh"

// Behaviour
// [R01] With enable set, one calibration starts automatically after about 16 minutes warm-up.
// [R02] A calibration run lasts about one second and only fine-tunes the front end.
// [R03] Only the first post warm-up run is automatic; later runs need a request.
// [R04] A software start command begins a calibration run at any time; the code ignores a start written while a run is in progress.
// [R05] With enable cleared, the post warm-up automatic run is skipped.
// [R06] Status has exactly three codes: uncalibrated, calibrated, recommended.
// [R07] Status stays uncalibrated until first calibration or end of warm-up.
// [R08] The automatic run completing moves status from uncalibrated to calibrated.
// [R09] With enable cleared, warm-up end moves status to recommended.
// [R10] While calibrated, temperature change beyond threshold moves status to recommended.
// [R11] Time since last calibration beyond the limit moves status to recommended.
// [R12] In recommended state no calibration starts on its own.
// [R13] A requested run completing sets calibrated and restarts time and temperature references.
// [R14] Temperature threshold and time limit are readable by software.
// [R15] After reset: uncalibrated, warm-up timer restarted, no run in progress.
module self_calibration_scheduler #(
	parameter [33:0] WARMUP_CYC = `CS_WARMUP_CYC,
	parameter [33:0] CALRUN_CYC = `CS_CALRUN_CYC,
	parameter [33:0] SEC_CYC    = `CS_SEC_CYC
) (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Front end
	input  wire [15:0] temperature,
	output reg         calActive,
	output reg  [1:0]  calStatus
);
	// ****************************************
	// States
	// ****************************************
	localparam [2:0] S_WARM = 3'b001;
	localparam [2:0] S_IDLE = 3'b010;
	localparam [2:0] S_RUN  = 3'b100;

	reg [2:0]  state_r;
	reg [2:0]  state_nxt;
	reg        enable_r;
	reg [15:0] tempThr_r;
	reg [31:0] timeLim_r;
	reg [15:0] tempRef_r;
	reg [31:0] elapsed_r;
	reg [33:0] secCnt_r;
	reg        startReq_r;

	wire       wrEn  = psel & penable & pwrite;
	wire       rdEn  = psel & ~pwrite;
	wire       known;
	wire       runLoad;
	wire       runDone;
	wire       warmDone;
	wire       warmLoad;
	wire [15:0] tempDelta;

	function [15:0] absDiff;
		input [15:0] a;
		input [15:0] b;
		begin
			absDiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	assign tempDelta = absDiff(temperature, tempRef_r);
	assign known = (paddr == `CS_OFF_CTRL) | (paddr == `CS_OFF_STATUS) |
		(paddr == `CS_OFF_TEMP) | (paddr == `CS_OFF_TEMPTHR) |
		(paddr == `CS_OFF_TIMELIM) | (paddr == `CS_OFF_ELAPSED);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~known;

	// ****************************************
	// Timers
	// ****************************************
	// The warm-up timer is loaded once in the cycle after reset release.
	reg warmArmed_r;
	assign warmLoad = ~warmArmed_r; // see [R15]

	cal_timer #(.WIDTH(34)) u_warm (
		.clk     (clk),
		.sys_rst (sys_rst),
		.load    (warmLoad),
		.count   (WARMUP_CYC),
		.abort   (1'b0),
		.running (),
		.done    (warmDone)
	);

	cal_timer #(.WIDTH(34)) u_run (
		.clk     (clk),
		.sys_rst (sys_rst),
		.load    (runLoad),
		.count   (CALRUN_CYC - 34'h1),
		.abort   (1'b0),
		.running (),
		.done    (runDone) // see [R02]
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_WARM: begin
				if (startReq_r) begin
					state_nxt = S_RUN; // see [R04]
				end else if (warmDone && enable_r) begin
					state_nxt = S_RUN; // see [R01]
				end else if (warmDone) begin
					state_nxt = S_IDLE; // see [R05]
				end
			end
			S_IDLE: begin
				// Only software starts a run here, whatever the status shows.
				if (startReq_r) begin
					state_nxt = S_RUN; // see [R03] [R12]
				end
			end
			S_RUN: begin
				if (runDone) begin
					state_nxt = S_IDLE;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	assign runLoad = (state_r != S_RUN) && (state_nxt == S_RUN);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r     <= S_WARM; // see [R15]
			warmArmed_r <= 1'b0;
			calActive   <= 1'b0;
			calStatus   <= `CS_ST_UNCAL; // see [R15]
			tempRef_r   <= 16'h0000;
			elapsed_r   <= 32'h0000_0000;
			secCnt_r    <= 34'h0;
		end else begin
			state_r     <= state_nxt;
			warmArmed_r <= 1'b1;
			calActive   <= (state_nxt == S_RUN);
			if (state_r == S_RUN && runDone) begin
				calStatus <= `CS_ST_CAL; // see [R08] [R13]
				tempRef_r <= temperature; // see [R13]
				elapsed_r <= 32'h0000_0000;
				secCnt_r  <= 34'h0;
			end else begin
				if (secCnt_r >= SEC_CYC - 34'h1) begin
					secCnt_r <= 34'h0;
					if (elapsed_r != 32'hffff_ffff) begin
						elapsed_r <= elapsed_r + 32'h1;
					end
				end else begin
					secCnt_r <= secCnt_r + 34'h1;
				end
				if (state_r == S_WARM && warmDone && !enable_r && !startReq_r) begin
					calStatus <= `CS_ST_RECOMMEND; // see [R09] [R07]
				end else if (calStatus == `CS_ST_CAL && state_r == S_IDLE) begin
					if (tempDelta > tempThr_r) begin
						calStatus <= `CS_ST_RECOMMEND; // see [R10]
					end else if (elapsed_r > timeLim_r) begin
						calStatus <= `CS_ST_RECOMMEND; // see [R11]
					end
				end
			end
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// The start bit is a self-clearing request held until the sequencer takes it.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			enable_r   <= `CS_RST_EN;
			tempThr_r  <= `CS_RST_TEMPTHR;
			timeLim_r  <= `CS_RST_TIMELIM;
			startReq_r <= 1'b0;
		end else begin
			if (runLoad) begin
				startReq_r <= 1'b0;
			end
			if (wrEn && paddr == `CS_OFF_CTRL) begin
				enable_r <= pwdata[`CS_CTRL_EN_BIT];
				if (pwdata[`CS_CTRL_START_BIT] && state_r != S_RUN) begin
					startReq_r <= 1'b1; // see [R04]
				end
			end
			if (wrEn && paddr == `CS_OFF_TEMPTHR) begin
				tempThr_r <= pwdata[15:0];
			end
			if (wrEn && paddr == `CS_OFF_TIMELIM) begin
				timeLim_r <= pwdata;
			end
		end
	end

	always @* begin
		prdata = 32'h0000_0000;
		if (rdEn) begin
			case (paddr)
				`CS_OFF_CTRL:    prdata = {30'h0, startReq_r, enable_r};
				`CS_OFF_STATUS:  prdata = {29'h0, calActive, calStatus}; // see [R06]
				`CS_OFF_TEMP:    prdata = {16'h0, tempRef_r};
				`CS_OFF_TEMPTHR: prdata = {16'h0, tempThr_r}; // see [R14]
				`CS_OFF_TIMELIM: prdata = timeLim_r; // see [R14]
				`CS_OFF_ELAPSED: prdata = elapsed_r;
				default:         prdata = 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: bench/cal_sched_chk.sv
// Purpose: Port checker for the calibration scheduler.
// Assumes: One clock domain, bound to the top module.
// Notes:   Start writes are traced so a run in recommended state needs a cause.
`timescale 1ns/1ns
`default_nettype none
`include "cal_sched_consts.vh"
module cal_sched_chk #(
	parameter [33:0] WARMUP_CYC = 34'd200,
	parameter [33:0] CALRUN_CYC = 34'd20,
	parameter [33:0] SEC_CYC    = 34'd10
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Front end
	input wire logic [15:0] temperature,
	input wire logic        calActive,
	input wire logic [1:0]  calStatus
);
	// ****
	// Helpers
	// ****
	logic [33:0] runCnt_r;
	wire         wrStart = psel & penable & pwrite & (paddr == `CS_OFF_CTRL) & pwdata[1];
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) runCnt_r <= 34'h0;
		else runCnt_r <= calActive ? runCnt_r + 34'h1 : 34'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_status_legal: assert property (calStatus != 2'h3)
		else $error("status code out of range");
	a_status_read: assert property (psel && !pwrite && paddr == `CS_OFF_STATUS |->
		prdata[2:0] == {calActive, calStatus}) else $error("status read wrong");
	a_reset_state: assert property ($fell(sys_rst) |-> calStatus == 2'h0 && !calActive)
		else $error("state after reset wrong");
	// A run that is never ended would hold the front end, so bound it.
	a_run_length: assert property (calActive |-> runCnt_r <= CALRUN_CYC)
		else $error("run too long");
	a_done_cal: assert property ($fell(calActive) |-> ##[0:1] calStatus == 2'h1)
		else $error("run end not calibrated");
	a_cal_cause: assert property ($changed(calStatus) && calStatus == 2'h1 |->
		$past(calActive) || $past(calActive, 2)) else $error("calibrated without run");
	a_recommend_idle: assert property ($changed(calStatus) && calStatus == 2'h2 |->
		!$past(calActive)) else $error("recommend during run");
	a_no_self_start: assert property ($rose(calActive) && $past(calStatus) == 2'h2 |->
		$past(wrStart, 2) || $past(wrStart, 3) || $past(wrStart, 4))
		else $error("run started on its own");
	c_run: cover property ($rose(calActive));
	c_recommend: cover property (calStatus == 2'h2);
	c_unmapped: cover property (pslverr);
endmodule
bind self_calibration_scheduler cal_sched_chk #(.WARMUP_CYC(WARMUP_CYC),
	.CALRUN_CYC(CALRUN_CYC), .SEC_CYC(SEC_CYC)) i_cal_sched_chk (.clk, .sys_rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .temperature,
	.calActive, .calStatus);
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the calibration scheduler.
// Assumes: Short warm-up, run and second counts set by parameter.
// Notes:   Registers are reached only through the APB task.
`timescale 1ns/1ns
`default_nettype none
`include "cal_sched_consts.vh"
module tb_top;
	// ****
	// Design and clock
	// ****
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] temperature = 16'h1000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        calActive;
	logic [1:0]  calStatus;
	logic [31:0] rd;
	logic        err;
	int          miscompares = 0;
	int          num_checks = 0;
	self_calibration_scheduler #(.WARMUP_CYC(34'd200), .CALRUN_CYC(34'd20),
		.SEC_CYC(34'd10)) i_self_calibration_scheduler (.clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .temperature, .calActive,
		.calStatus);
	initial begin
		forever #50 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task waitAct(input logic v);
		for (int i = 0; i < 400 && calActive !== v; i++) @(posedge clk);
	endtask
	task doReset;
		sys_rst <= 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
	endtask
	// ****
	// Scenarios
	// ****
	task t_regs;
		chk(calStatus, `CS_ST_UNCAL);
		chk(calActive, 1'b0);
		apb(1'b0, `CS_OFF_CTRL, 32'h0);
		chk(rd, 32'h0000_0001);
		chk(pready, 1'b1);
		apb(1'b0, `CS_OFF_TEMPTHR, 32'h0);
		chk(rd, 32'h0000_0100);
		apb(1'b0, `CS_OFF_TIMELIM, 32'h0);
		chk(rd, 32'h0000_0e10);
		apb(1'b0, 12'h018, 32'h0);
		chk(err, 1'b1);
		$display("t_regs done");
	endtask
	task t_off;
		apb(1'b1, `CS_OFF_CTRL, 32'h0);
		repeat (220) @(posedge clk);
		chk(calStatus, `CS_ST_RECOMMEND);
		chk(calActive, 1'b0);
		repeat (50) @(posedge clk);
		chk(calActive, 1'b0);
		apb(1'b1, `CS_OFF_CTRL, 32'h0000_0002);
		waitAct(1'b1);
		chk(calActive, 1'b1);
		waitAct(1'b0);
		chk(calStatus, `CS_ST_CAL);
		$display("t_off done");
	endtask
	task t_auto;
		repeat (150) @(posedge clk);
		chk(calStatus, `CS_ST_UNCAL);
		chk(calActive, 1'b0);
		waitAct(1'b1);
		chk(calActive, 1'b1);
		waitAct(1'b0);
		chk(calStatus, `CS_ST_CAL);
		repeat (300) @(posedge clk);
		chk(calActive, 1'b0);
		$display("t_auto done");
	endtask
	task t_temp;
		temperature <= 16'h1100;
		repeat (5) @(posedge clk);
		chk(calStatus, `CS_ST_CAL);
		temperature <= 16'h0eff;
		repeat (5) @(posedge clk);
		chk(calStatus, `CS_ST_RECOMMEND);
		repeat (50) @(posedge clk);
		chk(calActive, 1'b0);
		$display("t_temp done");
	endtask
	task t_time;
		apb(1'b1, `CS_OFF_TIMELIM, 32'h0000_0002);
		apb(1'b1, `CS_OFF_CTRL, 32'h0000_0003);
		waitAct(1'b1);
		waitAct(1'b0);
		chk(calStatus, `CS_ST_CAL);
		apb(1'b0, `CS_OFF_TEMP, 32'h0);
		chk(rd, 32'h0000_0eff);
		apb(1'b0, `CS_OFF_ELAPSED, 32'h0);
		chk(rd, 32'h0);
		repeat (15) @(posedge clk);
		chk(calStatus, `CS_ST_CAL);
		repeat (30) @(posedge clk);
		chk(calStatus, `CS_ST_RECOMMEND);
		$display("t_time done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		doReset;
		t_regs;
		t_off;
		doReset;
		t_auto;
		t_temp;
		t_time;
		summarize;
	end
	// The whole run needs about 1000 cycles, so this leaves a wide margin.
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		summarize;
	end
endmodule
`default_nettype wire
